// ==== verif/irqsi_src_model.sv ====
// Behavioural model of the external pin and port interrupt sources
`timescale 1ns/1ps
`default_nettype none
module irqsi_src_model
  import irqsi_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Levels the bench asks for
  input  wire irqsi_src_type want,
  // Request levels seen by the block
  output var  irqsi_src_type lvl
);
  // Sources move only just after an edge, like synchronous peripherals
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl <= '0;
    end else begin
      lvl <= want;
    end
  end
endmodule : irqsi_src_model
`default_nettype wire

// ==== verif/test_irq_source_identity_ext_gpio.sv ====
// Self-checking bench for the shared-line source identity registers
`timescale 1ns/1ps
`default_nettype none
module test_irq_source_identity_ext_gpio
  import irqsi_pkg::*;
;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              line3_req;
  logic              line4_req;
  logic              line5_req;
  logic              evt_irq;
  logic [DATA_W-1:0] rdata;
  logic              rerr;
  irqsi_src_type     want = '0;
  irqsi_src_type     lvl;
  int                fail_count = 0;
  int                compares = 0;

  always #20 pclk = ~pclk;

  irqsi_src_model model (.pclk(pclk), .presetn(presetn), .want(want), .lvl(lvl));

  irqsi_identity uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_pin_irq_one(lvl.ext),
    .port_zero_irq_flag(lvl.low[0]), .port_one_irq_flag(lvl.low[1]),
    .port_two_irq_flag(lvl.low[2]), .port_three_irq_flag(lvl.low[3]),
    .port_four_irq_flag(lvl.low[4]), .port_five_irq_flag(lvl.high[0]),
    .port_six_irq_flag(lvl.high[1]), .port_seven_irq_flag(lvl.high[2]),
    .port_eight_irq_flag(lvl.high[3]), .port_nine_irq_flag(lvl.high[4]),
    .port_ten_irq_flag(lvl.high[5]), .line3_req(line3_req), .line4_req(line4_req),
    .line5_req(line5_req), .evt_irq(evt_irq)
  );

  task automatic results();
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Registered pready: reading it right after the edge gives the sampled value
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_src(input irqsi_src_type v);
    @(posedge pclk);
    want <= v;
    repeat (4) @(posedge pclk);
  endtask : set_src

  task automatic check_ids(input irqsi_src_type v);
    apb(1'b0, OFS_EXT_ID, 32'h0);
    cmp(rdata, {31'h0, v.ext});
    apb(1'b0, OFS_LOW_ID, 32'h0);
    cmp(rdata, {27'h0, v.low});
    apb(1'b0, OFS_HIGH_ID, 32'h0);
    cmp(rdata, {26'h0, v.high});
    cmp({29'h0, line5_req, line4_req, line3_req}, {29'h0, |v.high, |v.low, v.ext});
  endtask : check_ids

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    check_ids(12'h000);
    for (int i = 0; i < EVT_W; i++) begin
      set_src(12'h001 << i);
      check_ids(12'h001 << i);
    end
    set_src(12'hfff);
    check_ids(12'hfff);
    set_src(12'h000);
    // Writes land while sources are quiet, so a stored value would show
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFS_EXT_ID + 12'(4 * k), 32'hffff_ffff);
      cmp({31'h0, rerr}, 32'h0);
    end
    check_ids(12'h000);
    apb(1'b0, 12'h018, 32'h0);
    cmp(rdata, 32'h0);
    cmp({31'h0, rerr}, 32'h1);
    apb(1'b0, OFS_EVT_STAT, 32'h0);
    cmp(rdata, 32'h0000_0fff);
    cmp({31'h0, evt_irq}, 32'h0);
    apb(1'b1, OFS_EVT_MASK, 32'h0000_0041);
    @(posedge pclk);
    cmp({31'h0, evt_irq}, 32'h1);
    apb(1'b1, OFS_EVT_STAT, 32'h0000_0001);
    @(posedge pclk);
    cmp({31'h0, evt_irq}, 32'h1);
    apb(1'b1, OFS_EVT_STAT, 32'h0000_0040);
    @(posedge pclk);
    cmp({31'h0, evt_irq}, 32'h0);
    apb(1'b0, OFS_EVT_STAT, 32'h0);
    cmp(rdata, 32'h0000_0fbe);
    apb(1'b0, OFS_EVT_MASK, 32'h0);
    cmp(rdata, 32'h0000_0041);
    set_src(12'h001);
    cmp({31'h0, evt_irq}, 32'h1);
    // Edge and its clear meet at one access edge: the edge wins
    set_src(12'h000);
    fork
      apb(1'b1, OFS_EVT_STAT, 32'h0000_0001);
      @(posedge pclk) want <= 12'h001;
    join
    apb(1'b0, OFS_EVT_STAT, 32'h0);
    cmp(rdata, 32'h0000_0fbf);
    results();
  end
endmodule : test_irq_source_identity_ext_gpio
`default_nettype wire

// ==== verilog/irqsi_evt_capture.sv ====
// Sticky rising-edge capture per source, write-one-to-clear, masked interrupt
`timescale 1ns/1ps
`default_nettype none
module irqsi_evt_capture
  import irqsi_pkg::*;
#(
  parameter int unsigned W = EVT_W
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Levels, clear strobes and next mask
  input  wire logic [W-1:0] lvl,
  input  wire logic [W-1:0] clr,
  input  wire logic [W-1:0] mask_d,
  // Status and interrupt
  output var  logic [W-1:0] stat_q,
  output var  logic         irq_q
);

  logic [W-1:0] prev_q;
  logic [W-1:0] set;
  logic [W-1:0] stat_d;

  for (genvar i = 0; i < W; i++) begin : g_bit
    assign set[i]    = lvl[i] & ~prev_q[i];
    // A new edge beats a clear in the same cycle
    assign stat_d[i] = set[i] | (stat_q[i] & ~clr[i]);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prev_q[i] <= 1'b0;
        stat_q[i] <= EVT_STAT_RST[i];
      end else begin
        prev_q[i] <= lvl[i];
        stat_q[i] <= stat_d[i];
      end
    end
  end

  // Built from next values so irq tracks status and mask with no lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_d & mask_d);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_set_wins: assert property (
    (|(set & clr)) |=> ((stat_q & $past(set & clr)) == $past(set & clr)))
    else $error("edge lost against a clear");

endmodule : irqsi_evt_capture
`default_nettype wire

// ==== verilog/irqsi_identity.sv ====
// Shared-line interrupt source identity registers with an APB slave
//
// Overview of operation
// - Line-3 identity bit 0 shows the external pin interrupt one request; bits 31:1 read 0.
// - Line-4 identity bits 4:0 show ports zero to four, one bit each; bits 31:5 read 0.
// - Line-5 identity bits 5:0 show ports five to ten, one bit each; bits 31:6 read 0.
// - The line-3 identity register sits at byte offset 0x0c, read-only, no reset value.
// - The line-4 identity register sits at byte offset 0x10, read-only, no reset value.
// - The line-5 identity register sits at byte offset 0x14, read-only, no reset value.
`timescale 1ns/1ps
`default_nettype none
module irqsi_identity
  import irqsi_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,

  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [STRB_W-1:0] pstrb,
  output wire logic [DATA_W-1:0] prdata,
  output wire logic              pready,
  output wire logic              pslverr,

  // External pin source
  input  wire logic              ext_pin_irq_one,

  // Low port sources
  input  wire logic              port_zero_irq_flag,
  input  wire logic              port_one_irq_flag,
  input  wire logic              port_two_irq_flag,
  input  wire logic              port_three_irq_flag,
  input  wire logic              port_four_irq_flag,

  // High port sources
  input  wire logic              port_five_irq_flag,
  input  wire logic              port_six_irq_flag,
  input  wire logic              port_seven_irq_flag,
  input  wire logic              port_eight_irq_flag,
  input  wire logic              port_nine_irq_flag,
  input  wire logic              port_ten_irq_flag,

  // Shared line requests
  output wire logic              line3_req,
  output wire logic              line4_req,
  output wire logic              line5_req,

  // Event interrupt
  output wire logic              evt_irq
);

  irqsi_apb_req_type req;
  irqsi_src_type     src;
  irqsi_sel_type     sel;
  logic              setup;
  logic              acc_wr;
  logic [EVT_W-1:0]  lane_m;
  logic [EVT_W-1:0]  clr;
  logic [EVT_W-1:0]  mask_d;
  logic [EVT_W-1:0]  mask_q;
  logic [EVT_W-1:0]  stat_q;
  logic [DATA_W-1:0] rd_d;
  logic [DATA_W-1:0] prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              evt_irq_q;
  logic              line3_q;
  logic              line4_q;
  logic              line5_q;

  assign req = '{
    psel:    psel,
    penable: penable,
    pwrite:  pwrite,
    paddr:   paddr,
    pwdata:  pwdata,
    pstrb:   pstrb
  };

  // Identity bits are wired straight from the request levels
  assign src.ext  = ext_pin_irq_one;
  assign src.low  = {port_four_irq_flag,
                     port_three_irq_flag,
                     port_two_irq_flag,
                     port_one_irq_flag,
                     port_zero_irq_flag};
  assign src.high = {port_ten_irq_flag,
                     port_nine_irq_flag,
                     port_eight_irq_flag,
                     port_seven_irq_flag,
                     port_six_irq_flag,
                     port_five_irq_flag};

  function automatic irqsi_sel_type addr_sel(input logic [ADDR_W-1:0] a);
    irqsi_sel_type s;
    s = SEL_NONE;
    case (a)
      OFS_EXT_ID:   s = SEL_EXT;
      OFS_LOW_ID:   s = SEL_LOW;
      OFS_HIGH_ID:  s = SEL_HIGH;
      OFS_EVT_STAT: s = SEL_STAT;
      OFS_EVT_MASK: s = SEL_MASK;
      default:      s = SEL_NONE;
    endcase
    return s;
  endfunction : addr_sel

  assign sel    = addr_sel(req.paddr);
  assign setup  = req.psel & ~req.penable;
  // Writes act only at the access edge, when ready is sampled high
  assign acc_wr = req.psel & req.penable & pready_q & req.pwrite;
  assign lane_m = {{LANE1_W{req.pstrb[1]}}, {LANE0_W{req.pstrb[0]}}};

  // Reserved bits stay zero; the value is caught at the setup edge
  always_comb begin
    rd_d = RD_ZERO;
    case (sel)
      SEL_EXT:  rd_d[EXT_W-1:0]  = src.ext;
      SEL_LOW:  rd_d[LOW_W-1:0]  = src.low;
      SEL_HIGH: rd_d[HIGH_W-1:0] = src.high;
      SEL_STAT: rd_d[EVT_W-1:0]  = stat_q;
      SEL_MASK: rd_d[EVT_W-1:0]  = mask_q;
      default:  rd_d = RD_ZERO;
    endcase
  end

  // Identity offsets decode to no write path, so writes there vanish
  always_comb begin
    clr    = '0;
    mask_d = mask_q;
    if (acc_wr && (sel == SEL_STAT)) begin
      clr = req.pwdata[EVT_W-1:0] & lane_m;
    end
    if (acc_wr && (sel == SEL_MASK)) begin
      mask_d = (mask_q & ~lane_m) | (req.pwdata[EVT_W-1:0] & lane_m);
    end
  end

  // One wait-free access phase: ready rises in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & (sel == SEL_NONE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= RD_ZERO;
    end else if (setup) begin
      prdata_q <= req.pwrite ? RD_ZERO : rd_d;
    end
  end

  // Mask is plain storage; the interrupt follows it through the capture block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= EVT_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  irqsi_evt_capture #(
    .W      (EVT_W)
  ) u_evt (
    .pclk   (pclk),
    .presetn(presetn),
    .lvl    (src),
    .clr    (clr),
    .mask_d (mask_d),
    .stat_q (stat_q),
    .irq_q  (evt_irq_q)
  );

  // Line requests are registered so the outputs come straight from flops
  irqsi_line_merge u_merge (
    .pclk       (pclk),
    .presetn    (presetn),
    .src        (src),
    .line3_req_q(line3_q),
    .line4_req_q(line4_q),
    .line5_req_q(line5_q)
  );

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign evt_irq   = evt_irq_q;
  assign line3_req = line3_q;
  assign line4_req = line4_q;
  assign line5_req = line5_q;

  // Checks below watch only what this block drives
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rd_setup(logic [ADDR_W-1:0] a);
    psel && !penable && !pwrite && (paddr == a);
  endsequence

  property id_read(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] v);
    rd_setup(a) |=> (prdata_q == $past(v));
  endproperty

  logic [DATA_W-1:0] ext_word;
  logic [DATA_W-1:0] low_word;
  logic [DATA_W-1:0] high_word;
  logic [EVT_W-1:0]  src_v;

  // Expected words come from the pins, so a swapped source wiring would show
  always_comb begin
    ext_word  = RD_ZERO;
    low_word  = RD_ZERO;
    high_word = RD_ZERO;
    ext_word[EXT_W-1:0]   = ext_pin_irq_one;
    low_word[LOW_W-1:0]   = {port_four_irq_flag,
                             port_three_irq_flag,
                             port_two_irq_flag,
                             port_one_irq_flag,
                             port_zero_irq_flag};
    high_word[HIGH_W-1:0] = {port_ten_irq_flag,
                             port_nine_irq_flag,
                             port_eight_irq_flag,
                             port_seven_irq_flag,
                             port_six_irq_flag,
                             port_five_irq_flag};
  end

  assign src_v = src;

  chk_ext_id_read: assert property (id_read(OFS_EXT_ID, ext_word))
    else $error("line-3 identity read wrong");

  chk_low_id_read: assert property (id_read(OFS_LOW_ID, low_word))
    else $error("line-4 identity read wrong");

  chk_high_id_read: assert property (id_read(OFS_HIGH_ID, high_word))
    else $error("line-5 identity read wrong");

  chk_ext_id_map: assert property (
    rd_setup(OFS_EXT_ID) |=> pready_q && !pslverr_q ##1 !pready_q)
    else $error("line-3 identity offset not decoded");

  chk_low_id_map: assert property (
    (setup && (paddr == OFS_LOW_ID)) |-> (sel == SEL_LOW) ##1 !pslverr_q)
    else $error("line-4 identity offset not decoded");

  chk_high_id_map: assert property (
    (setup && (paddr == OFS_HIGH_ID))
      |=> pready_q && !pslverr_q && (prdata_q[DATA_W-1:HIGH_W] == '0))
    else $error("line-5 identity offset not decoded");

  chk_id_wr_ignored: assert property (
    (acc_wr && ((sel == SEL_EXT) || (sel == SEL_LOW) || (sel == SEL_HIGH)))
      |=> $stable(mask_q) && ($past(stat_q) & ~stat_q) == '0)
    else $error("write to identity register had an effect");

  chk_id_rd_quiet: assert property (
    (psel && penable && pready_q && !pwrite) |=> $stable(mask_q))
    else $error("read disturbed the mask");

  chk_line_follow: assert property (
    (line3_q == $past(src.ext)) && (line4_q == $past(|src.low))
      && (line5_q == $past(|src.high)))
    else $error("line request not following its sources");

  chk_unmapped_err: assert property (
    (setup && (sel == SEL_NONE)) |=> pslverr_q && pready_q)
    else $error("unmapped offset not refused");

  chk_irq_level: assert property (evt_irq_q == |(stat_q & mask_q))
    else $error("interrupt output disagrees with status and mask");

  chk_mask_write: assert property (
    (acc_wr && (sel == SEL_MASK) && (pstrb[1:0] == 2'b11))
      |=> (mask_q == $past(pwdata[EVT_W-1:0])))
    else $error("mask write lost");

  // Read data only moves at a setup edge; software may sample it late
  chk_rdata_hold: assert property (!setup |=> $stable(prdata_q))
    else $error("read data moved outside a setup edge");

  chk_write_rdata: assert property ((setup && pwrite) |=> (prdata_q == RD_ZERO))
    else $error("write returned read data");

  chk_ready_once: assert property (pready_q |=> !pready_q)
    else $error("ready held longer than one access cycle");

  chk_err_with_ready: assert property (pslverr_q |-> pready_q)
    else $error("error response without ready");

  chk_id_wr_accepted: assert property (
    (setup && pwrite && (sel inside {SEL_EXT, SEL_LOW, SEL_HIGH})) |=> !pslverr_q)
    else $error("write to identity register refused");

  // Line requests against the pins, independent of the internal source vector
  chk_line_pins: assert property (
    (line3_q == $past(|ext_word)) && (line4_q == $past(|low_word))
      && (line5_q == $past(|high_word)))
    else $error("line request disagrees with its pins");

  // A clear only sticks where no new edge arrives in the same cycle
  chk_stat_w1c: assert property (
    (acc_wr && (sel == SEL_STAT)) |=> ((stat_q & $past(clr & ~src_v)) == '0))
    else $error("status bit survived its clear");

  chk_stat_sticky: assert property (
    (($past(stat_q) & ~stat_q & ~$past(clr)) == '0))
    else $error("status bit dropped without a clear");

  chk_edge_sets: assert property (
    $past(presetn) |-> ((stat_q & $past(src_v) & ~$past(src_v, 2))
      == ($past(src_v) & ~$past(src_v, 2))))
    else $error("rising source missed in status");

  // Each port lands on its own bit of its identity word
  for (genvar i = 0; i < LOW_W; i++) begin : g_low_chk
    chk_low_bit: assert property (
      rd_setup(OFS_LOW_ID) |=> (prdata_q[i] == $past(low_word[i])))
      else $error("line-4 identity bit misplaced");
  end

  for (genvar i = 0; i < HIGH_W; i++) begin : g_high_chk
    chk_high_bit: assert property (
      rd_setup(OFS_HIGH_ID) |=> (prdata_q[i] == $past(high_word[i])))
      else $error("line-5 identity bit misplaced");
  end

  cov_ext_read: cover property (rd_setup(OFS_EXT_ID) ##1 prdata_q[0]);
  cov_low_read: cover property (rd_setup(OFS_LOW_ID) ##1 (prdata_q != RD_ZERO));
  cov_high_read: cover property (rd_setup(OFS_HIGH_ID) ##1 (prdata_q != RD_ZERO));
  cov_irq_clear: cover property ($fell(evt_irq_q) && $past(acc_wr));
  cov_set_beats_clr: cover property (
    acc_wr && (sel == SEL_STAT) && (|(clr & src_v & ~$past(src_v))));

endmodule : irqsi_identity
`default_nettype wire

// ==== verilog/irqsi_line_merge.sv ====
// Merges the sources of each shared line into a registered line request
`timescale 1ns/1ps
`default_nettype none
module irqsi_line_merge
  import irqsi_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Source levels
  input  wire irqsi_src_type src,
  // Line requests
  output var  logic          line3_req_q,
  output var  logic          line4_req_q,
  output var  logic          line5_req_q
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line3_req_q <= 1'b0;
      line4_req_q <= 1'b0;
      line5_req_q <= 1'b0;
    end else begin
      line3_req_q <= src.ext;
      line4_req_q <= |src.low;
      line5_req_q <= |src.high;
    end
  end

endmodule : irqsi_line_merge
`default_nettype wire

// ==== verilog/irqsi_pkg.sv ====
// Constants and carrier types for the shared-line source identity block
package irqsi_pkg;

  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned STRB_W  = 4;
  localparam int unsigned EXT_W   = 1;
  localparam int unsigned LOW_W   = 5;
  localparam int unsigned HIGH_W  = 6;
  localparam int unsigned EVT_W   = EXT_W + LOW_W + HIGH_W;
  localparam int unsigned LANE0_W = 8;
  localparam int unsigned LANE1_W = EVT_W - LANE0_W;

  // Byte offsets from the block base
  localparam logic [ADDR_W-1:0] OFS_EXT_ID   = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_LOW_ID   = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_HIGH_ID  = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 12'h104;

  // Reset values
  localparam logic [EVT_W-1:0]  EVT_STAT_RST = 12'h000;
  localparam logic [EVT_W-1:0]  EVT_MASK_RST = 12'h000;
  localparam logic [DATA_W-1:0] RD_ZERO      = 32'h0000_0000;

  // Event vector layout: ext at bit 0, low ports 1..5, high ports 6..11
  typedef struct packed {
    logic [HIGH_W-1:0] high;
    logic [LOW_W-1:0]  low;
    logic              ext;
  } irqsi_src_type;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
  } irqsi_apb_req_type;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_EXT  = 3'b001,
    SEL_LOW  = 3'b010,
    SEL_HIGH = 3'b011,
    SEL_STAT = 3'b100,
    SEL_MASK = 3'b101
  } irqsi_sel_type;

endpackage : irqsi_pkg
